// ==== rtl/pdm_mode_sequencer.sv ====
// Power-mode sequencer of a four-channel PDM-to-TDM converter: control registers,
// sleep/wake timing, sleep status and a TDM transmitter gated by the power state.
// Assumes host-supplied bclk and fsync pins, sampled on the 100 MHz core clock.
`timescale 1ns/100ps
`default_nettype none

`include "pdm_seq_regs.svh"

//
// Contract
// - Spend 1 ms initializing after power, then sit in sleep; no access before.
// - Wake sequence completes within 1 ms; host waits that long.
// - Powered and clocked, device sends channel data on TDM bus.
// - Sleep entry ramps down and powers off within 6 ms.
// - Sleep status bit 7 reports shutdown done; host stops clocks after.
// - Sleep keeps every register value.
// - Device answers control writes at 8-bit address 0x9C.
module pdm_mode_sequencer
  import pdm_seq_pkg::*;
#(
  parameter int unsigned INIT_CYCLES  = `CYC_INIT,
  parameter int unsigned WAKE_CYCLES  = `CYC_WAKE,
  parameter int unsigned SLEEP_CYCLES = `CYC_SLEEP,
  parameter int unsigned SLOTS        = `TDM_SLOTS,
  parameter int unsigned WORD_BITS    = `TDM_WORD_BITS
)(
  // Clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  // Control port pins
  input  wire logic                 scl,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // Audio frame clocks from host, TDM data out
  input  wire logic                 bclk,
  input  wire logic                 fsync,
  output logic                      sdout,
  // Recorded samples, one word per channel
  input  wire logic [4*WORD_BITS-1:0] chan_data,
  // Power state outputs
  output logic                      converter_on,
  output logic                      pll_on,
  output logic                      regulator_internal,
  output logic                      sleeping
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (SLOTS < 1 || SLOTS > 4) begin : g_bad_slots
    $error("SLOTS must be 1 to 4");
  end
  if (WORD_BITS < 8 || WORD_BITS > 32) begin : g_bad_word
    $error("WORD_BITS must be 8 to 32");
  end
  if (INIT_CYCLES < 1 || WAKE_CYCLES < 1 || SLEEP_CYCLES < 1) begin : g_bad_time
    $error("Timing counts must be at least one cycle");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  pwr_state_t state;
  logic [7:0]  sleep_power_control;
  logic [7:0]  pdm_clock_pin_config;
  logic [7:0]  pdm_data_pin_config;
  logic [7:0]  bias_pin_function_config;
  logic [7:0]  channel_two_source_config;
  logic [7:0]  input_channel_enable;
  logic [7:0]  output_slot_enable;
  logic [7:0]  converter_pll_power_up;
  logic        sleep_done_flag;
  logic [31:0] timer;
  reg_wr_t     wr;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;

  // Control port stays deaf until initialization ends
  wire bus_enable = (state != ST_INIT);

  i2c_reg_slave u_ctl (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .scl     (scl),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .enable  (bus_enable),
    .wr      (wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------------
  // Write decode and read data select
  // ----------------------------------------------------------------------
  wire wr_sleep  = wr.valid & (wr.addr == `OFS_SLEEP_CTRL);
  wire wr_swrst  = wr.valid & (wr.addr == `OFS_SWRESET) & wr.data[`BIT_SWRESET];
  wire wake_req  = wr_sleep & wr.data[`BIT_SLEEP_N];
  wire sleep_req = wr_sleep & ~wr.data[`BIT_SLEEP_N];
  wire timer_done = (timer == 32'h0);

  always_comb begin
    case (rd_addr)
      `OFS_SLEEP_CTRL:   rd_data = sleep_power_control;
      `OFS_PDM_CLK_PIN:  rd_data = pdm_clock_pin_config;
      `OFS_PDM_DATA_PIN: rd_data = pdm_data_pin_config;
      `OFS_BIAS_PIN:     rd_data = bias_pin_function_config;
      `OFS_CH2_SRC:      rd_data = channel_two_source_config;
      `OFS_IN_CH_EN:     rd_data = input_channel_enable;
      `OFS_OUT_SLOT_EN:  rd_data = output_slot_enable;
      `OFS_PWR_UP:       rd_data = converter_pll_power_up;
      `OFS_SLEEP_STATUS: rd_data = {sleep_done_flag, 7'h00};
      default:           rd_data = `RST_BYTE;
    endcase
  end

  // Configuration bytes; untouched by sleep, cleared only by resets
  always_ff @(posedge clk) begin
    if (!rstn || (ce && wr_swrst)) begin
      sleep_power_control       <= `RST_BYTE;
      pdm_clock_pin_config      <= `RST_BYTE;
      pdm_data_pin_config       <= `RST_BYTE;
      bias_pin_function_config  <= `RST_BYTE;
      channel_two_source_config <= `RST_BYTE;
      input_channel_enable      <= `RST_BYTE;
      output_slot_enable        <= `RST_BYTE;
      converter_pll_power_up    <= `RST_BYTE;
    end else if (ce && wr.valid) begin
      case (wr.addr)
        `OFS_SLEEP_CTRL:   sleep_power_control       <= wr.data;
        `OFS_PDM_CLK_PIN:  pdm_clock_pin_config      <= wr.data;
        `OFS_PDM_DATA_PIN: pdm_data_pin_config       <= wr.data;
        `OFS_BIAS_PIN:     bias_pin_function_config  <= wr.data;
        `OFS_CH2_SRC:      channel_two_source_config <= wr.data;
        `OFS_IN_CH_EN:     input_channel_enable      <= wr.data;
        `OFS_OUT_SLOT_EN:  output_slot_enable        <= wr.data;
        `OFS_PWR_UP:       converter_pll_power_up    <= wr.data;
        default:           ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Power-mode state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state           <= ST_INIT;
      timer           <= INIT_CYCLES - 1;
      sleep_done_flag <= 1'b0;
    end else if (ce) begin
      if (wr_swrst) begin
        state           <= ST_SLEEP;
        sleep_done_flag <= 1'b1;
      end else begin
        case (state)
          ST_INIT: begin
            if (timer_done) begin
              state           <= ST_SLEEP;
              sleep_done_flag <= 1'b1;
            end else
              timer <= timer - 32'h1;
          end
          ST_SLEEP: begin
            if (wake_req) begin
              state           <= ST_WAKING;
              timer           <= WAKE_CYCLES - 1;
              sleep_done_flag <= 1'b0;
            end
          end
          ST_WAKING: begin
            if (sleep_req) begin
              state <= ST_RAMPDN;
              timer <= SLEEP_CYCLES - 1;
            end else if (timer_done)
              state <= ST_ACTIVE;
            else
              timer <= timer - 32'h1;
          end
          ST_ACTIVE: begin
            if (sleep_req) begin
              state <= ST_RAMPDN;
              timer <= SLEEP_CYCLES - 1;
            end
          end
          // Wake writes are dropped here; host waits for the done flag first
          ST_RAMPDN: begin
            if (timer_done) begin
              state           <= ST_SLEEP;
              sleep_done_flag <= 1'b1;
            end else
              timer <= timer - 32'h1;
          end
          default: state <= ST_INIT;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------------
  wire active = (state == ST_ACTIVE);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      converter_on       <= 1'b0;
      pll_on             <= 1'b0;
      regulator_internal <= 1'b0;
      sleeping           <= 1'b0;
    end else if (ce) begin
      converter_on       <= active & converter_pll_power_up[`BIT_PWR_CONV];
      pll_on             <= active & converter_pll_power_up[`BIT_PWR_PLL];
      regulator_internal <= (state != ST_INIT) & sleep_power_control[`BIT_REG_SELECT];
      sleeping           <= sleep_done_flag;
    end
  end

  // ----------------------------------------------------------------------
  // TDM transmitter
  // ----------------------------------------------------------------------
  logic [2:0] bclk_s;
  logic [2:0] fs_s;
  logic       bclk_lvl;
  logic       fs_lvl;
  logic [7:0] bitpos;
  logic [4*WORD_BITS-1:0] frame_word;

  wire bclk_hi   = bclk_s[1] & bclk_s[2];
  wire bclk_lo   = ~bclk_s[1] & ~bclk_s[2];
  wire fs_hi     = fs_s[1] & fs_s[2];
  wire fs_lo     = ~fs_s[1] & ~fs_s[2];
  wire next_bclk_lvl = bclk_hi ? 1'b1 : (bclk_lo ? 1'b0 : bclk_lvl);
  wire next_fs_lvl   = fs_hi ? 1'b1 : (fs_lo ? 1'b0 : fs_lvl);
  frame_clk_t fc;
  assign fc = '{bclk_rise: next_bclk_lvl & ~bclk_lvl,
                bclk_fall: ~next_bclk_lvl & bclk_lvl,
                fsync:     fs_lvl};

  // Disabled slots or channels send zero so the bus stays defined
  logic [4*WORD_BITS-1:0] masked;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_slot
    wire on = output_slot_enable[7-g] & input_channel_enable[7-g] & (g < SLOTS);
    assign masked[(4-g)*WORD_BITS-1 -: WORD_BITS] = on ? chan_data[(4-g)*WORD_BITS-1 -: WORD_BITS]
                                                       : '0;
  end

  wire in_frame = (bitpos < 8'(SLOTS * WORD_BITS));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bclk_s     <= 3'h0;
      fs_s       <= 3'h0;
      bclk_lvl   <= 1'b0;
      fs_lvl     <= 1'b0;
      bitpos     <= 8'hFF;
      frame_word <= '0;
      sdout      <= 1'b0;
    end else if (ce) begin
      bclk_s   <= {bclk_s[1:0], bclk};
      fs_s     <= {fs_s[1:0], fsync};
      bclk_lvl <= next_bclk_lvl;
      if (fc.bclk_rise)
        fs_lvl <= next_fs_lvl;
      if (fc.bclk_rise && next_fs_lvl && !fc.fsync) begin
        bitpos     <= 8'h00;
        frame_word <= masked;
      end else if (fc.bclk_fall) begin
        // Data changes on falling bit clock, one bit after frame sync
        if (converter_on && in_frame) begin
          sdout      <= frame_word[4*WORD_BITS-1];
          frame_word <= {frame_word[4*WORD_BITS-2:0], 1'b0};
          bitpos     <= bitpos + 8'h01;
        end else
          sdout <= 1'b0;
      end
    end
  end

endmodule // pdm_mode_sequencer

`default_nettype wire

// ==== rtl/pdm_seq_regs.svh ====
// Register offsets, field positions, reset values and timing for the power-mode sequencer.
// Assumes a 100 MHz core clock; included by the package-using design files.
`ifndef PDM_SEQ_REGS_SVH
`define PDM_SEQ_REGS_SVH

// ----------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------
`define DEV_ADDR_WRITE     8'h9C
`define DEV_ADDR_7BIT      7'h4E

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_PAGE           8'h00
`define OFS_SWRESET        8'h01
`define OFS_SLEEP_CTRL     8'h02
`define OFS_PDM_CLK_PIN    8'h22
`define OFS_PDM_DATA_PIN   8'h2B
`define OFS_BIAS_PIN       8'h3B
`define OFS_CH2_SRC        8'h41
`define OFS_IN_CH_EN       8'h73
`define OFS_OUT_SLOT_EN    8'h74
`define OFS_PWR_UP         8'h75
`define OFS_SLEEP_STATUS   8'h77

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define BIT_SLEEP_N        0
`define BIT_REG_SELECT     7
`define BIT_SLEEP_DONE     7
`define BIT_SWRESET        0
`define BIT_PWR_CONV       6
`define BIT_PWR_PLL        5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BYTE           8'h00

// ----------------------------------------------------------------------
// Timing, in microseconds, with cycle counts derived at 100 MHz; TDM slot count and word size
// ----------------------------------------------------------------------
`define CLK_MHZ            100
`define T_INIT_US          1000
`define T_WAKE_US          1000
`define T_SLEEP_US         6000
`define CYC_INIT           (`T_INIT_US * `CLK_MHZ)
`define CYC_WAKE           (`T_WAKE_US * `CLK_MHZ)
`define CYC_SLEEP          (`T_SLEEP_US * `CLK_MHZ)
`define TDM_SLOTS          4
`define TDM_WORD_BITS      32

`endif

// ==== rtl/pdm_seq_pkg.sv ====
// Types shared by the power-mode sequencer design files.
// Assumes nothing beyond a SystemVerilog compiler.
package pdm_seq_pkg;

  typedef enum logic [2:0] {
    ST_INIT   = 3'b000,
    ST_SLEEP  = 3'b001,
    ST_WAKING = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_RAMPDN = 3'b100
  } pwr_state_t;

  // One completed register write from the serial control slave
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  // Synchronised audio frame clocks with edge marks
  typedef struct packed {
    logic bclk_rise;
    logic bclk_fall;
    logic fsync;
  } frame_clk_t;

endpackage

// ==== rtl/i2c_reg_slave.sv ====
// Serial control-port slave: fixed address, one pointer byte, then data bytes with auto-increment.
// Assumes scl and sda_in are raw pins; both enter three-flop chains, scl tapped from the second stage on, sda_in from the first.
`timescale 1ns/100ps
`default_nettype none

`include "pdm_seq_regs.svh"

module i2c_reg_slave
  import pdm_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // Bus pins
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Register side
  input  wire logic       enable,
  output reg_wr_t         wr,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_PTR  = 3'b010,
    SL_WDAT = 3'b011,
    SL_RDAT = 3'b100
  } slv_state_t;

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  slv_state_t st;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [7:0] ptr;
  logic       ack_phase;
  logic       rd_nack;

  // Change counts only once stages two and three agree
  wire scl_hi   = scl_s[1] & scl_s[2];
  wire scl_lo   = ~scl_s[1] & ~scl_s[2];
  wire sda_now  = sda_s[1];
  wire sda_prev = sda_s[2];
  logic scl_lvl;
  wire scl_rise = scl_hi & ~scl_lvl;
  wire scl_fall = scl_lo & scl_lvl;
  wire start_c  = scl_hi & scl_lvl & sda_prev & ~sda_now & (sda_s[1] == sda_s[0]);
  wire stop_c   = scl_hi & scl_lvl & ~sda_prev & sda_now & (sda_s[1] == sda_s[0]);
  wire byte_in  = (bitcnt == 4'h8);
  wire [7:0] next_shreg = {shreg[6:0], sda_now};

  assign rd_addr = ptr;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_s   <= 3'h7;
      sda_s   <= 3'h7;
      scl_lvl <= 1'b1;
    end else if (ce) begin
      scl_s <= {scl_s[1:0], scl};
      sda_s <= {sda_s[1:0], sda_in};
      if (scl_hi)
        scl_lvl <= 1'b1;
      else if (scl_lo)
        scl_lvl <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st        <= SL_IDLE;
      shreg     <= 8'h00;
      bitcnt    <= 4'h0;
      ptr       <= 8'h00;
      ack_phase <= 1'b0;
      rd_nack   <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      wr        <= '0;
    end else if (ce) begin
      wr.valid <= 1'b0;
      if (start_c && enable) begin
        st        <= SL_ADDR;
        bitcnt    <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (stop_c || !enable) begin
        st     <= SL_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise && st != SL_IDLE) begin
        if (ack_phase) begin
          rd_nack <= sda_now;
        end else if (st != SL_RDAT) begin
          shreg  <= next_shreg;
          bitcnt <= bitcnt + 4'h1;
        end else begin
          bitcnt <= bitcnt + 4'h1;
        end
      end else if (scl_fall && st != SL_IDLE) begin
        if (ack_phase) begin
          ack_phase <= 1'b0;
          bitcnt    <= 4'h0;
          sda_oe    <= 1'b0;
          if (st == SL_RDAT) begin
            if (rd_nack)
              st <= SL_IDLE;
            else begin
              sda_oe  <= ~rd_data[7];
              sda_out <= 1'b0;
              shreg   <= {rd_data[6:0], 1'b0};
            end
          end
        end else if (byte_in) begin
          ack_phase <= 1'b1;
          case (st)
            SL_ADDR: begin
              if (shreg[7:1] == `DEV_ADDR_7BIT) begin
                sda_oe <= 1'b1;
                st     <= shreg[0] ? SL_RDAT : SL_PTR;
                if (shreg[0])
                  ptr <= ptr;
              end else begin
                st <= SL_IDLE;
              end
            end
            SL_PTR: begin
              sda_oe <= 1'b1;
              ptr    <= shreg;
              st     <= SL_WDAT;
            end
            SL_WDAT: begin
              sda_oe <= 1'b1;
              wr     <= '{valid: 1'b1, addr: ptr, data: shreg};
              ptr    <= ptr + 8'h01;
            end
            SL_RDAT: begin
              sda_oe <= 1'b0;
              ptr    <= ptr + 8'h01;
            end
            default: st <= SL_IDLE;
          endcase
        end else if (st == SL_RDAT) begin
          sda_oe <= ~shreg[7];
          shreg  <= {shreg[6:0], 1'b0};
        end
      end
    end
  end

endmodule // i2c_reg_slave

`default_nettype wire

// ==== testbench/pdm_seq_chk.sv ====
// Port checks of the power-mode sequencer.
// Assumes ce held high; bound to the design below.
`timescale 1ns/100ps
`default_nettype none

module pdm_seq_chk #(
  parameter int INIT_CYCLES = 300
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins
  input wire logic scl,
  input wire logic bclk,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic sdout,
  // Power state
  input wire logic converter_on,
  input wire logic pll_on,
  input wire logic regulator_internal,
  input wire logic sleeping
);
  int since_rst;

  // Saturates so the end-of-init check fires once
  always_ff @(posedge clk) begin
    if (!rstn) begin
      since_rst <= 0;
    end else if (since_rst < INIT_CYCLES + 8) begin
      since_rst <= since_rst + 1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_init_quiet: assert property (since_rst < INIT_CYCLES - 1 |->
    !sleeping && !sda_oe && !regulator_internal && !converter_on) else $error("active during init");
  chk_init_ends: assert property (since_rst == INIT_CYCLES + 6 |-> sleeping)
    else $error("init did not end in sleep");
  chk_ack_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("data line moved with clock high");
  chk_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  chk_drive_hold: assert property ($rose(sda_oe) |-> (sda_oe && !sda_out)[*8])
    else $error("data line drive shorter than a bit");
  chk_power_awake: assert property (converter_on || pll_on |-> !sleeping)
    else $error("power on while asleep");
  chk_wake_dark: assert property ($fell(sleeping) |-> !converter_on[*8])
    else $error("converter on during wake-up");
  chk_ramp_first: assert property ($rose(sleeping) && !sda_oe |->
    !$past(converter_on, 8) && !$past(pll_on, 8)) else $error("sleep without ramp-down");
  chk_idle_sdout: assert property (!converter_on[*3] |-> !sdout)
    else $error("serial data while powered down");
  chk_sdout_bclk: assert property ($changed(sdout) && converter_on |-> !bclk)
    else $error("serial data moved outside bit clock low");
endmodule // pdm_seq_chk

bind pdm_mode_sequencer pdm_seq_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .scl(scl), .bclk(bclk), .sda_out(sda_out), .sda_oe(sda_oe),
  .sdout(sdout), .converter_on(converter_on), .pll_on(pll_on),
  .regulator_internal(regulator_internal), .sleeping(sleeping));

`default_nettype wire

// ==== testbench/host_model.sv ====
// Host processor: control-port master and frame clock source.
// Assumes a pulled-up data line and a 100 MHz clk.
`timescale 1ns/100ps
`default_nettype none

module host_model (
  // Clock and observed lines
  input  wire logic clk,
  input  wire logic sda,
  input  wire logic sdout,
  // Driven pins
  output logic      scl,
  output logic      sda_pull,
  output logic      bclk,
  output logic      fsync
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    bclk = 1'b0;
    fsync = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Tail hold keeps data edges clear of the clock fall
  task automatic put_bit(input logic b, output logic rb);
    sda_pull = ~b;
    hold(6);
    scl = 1'b1;
    hold(4);
    rb = sda;
    hold(4);
    scl = 1'b0;
    hold(2);
  endtask

  task automatic start();
    sda_pull = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_pull = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(2);
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_pull = 1'b0;
    hold(8);
  endtask

  // Ninth bit released: reads the ack, or sends a nack
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(1'b1, ack);
  endtask

  // Bit clock stands still outside the frame
  task automatic frame(output logic [127:0] cap);
    fsync = 1'b1;
    #62.5 bclk = 1'b1;
    #62.5 bclk = 1'b0;
    fsync = 1'b0;
    for (int i = 127; i >= 0; i--) begin
      #62.5 bclk = 1'b1;
      cap[i] = sdout;
      #62.5 bclk = 1'b0;
    end
  endtask
endmodule // host_model

`default_nettype wire

// ==== testbench/testbench.sv ====
// Bench for the power-mode sequencer: wake, configure, record, sleep.
// Assumes host_model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none

`define CHECK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module testbench;
  localparam int INIT = 300;
  localparam int WAKE = 50;
  localparam int SLP  = 100;

  logic         clk;
  logic         rstn;
  logic         sda_out;
  logic         sda_oe;
  logic         sda_pull;
  wire logic    sda;
  logic         scl;
  logic         bclk;
  logic         fsync;
  logic         sdout;
  logic [127:0] chan_data;
  logic         converter_on;
  logic         pll_on;
  logic         regulator_internal;
  logic         sleeping;
  int           bad_count;
  int           comparisons;
  int           seed;

  assign sda = ~(sda_oe | sda_pull);

  pdm_mode_sequencer #(.INIT_CYCLES(INIT), .WAKE_CYCLES(WAKE), .SLEEP_CYCLES(SLP)) uut (
    .clk(clk), .rstn(rstn), .ce(1'b1), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .bclk(bclk), .fsync(fsync), .sdout(sdout), .chan_data(chan_data),
    .converter_on(converter_on), .pll_on(pll_on), .regulator_internal(regulator_internal),
    .sleeping(sleeping));

  host_model host (.clk(clk), .sda(sda), .sdout(sdout), .scl(scl), .sda_pull(sda_pull),
    .bclk(bclk), .fsync(fsync));

  function automatic logic [127:0] tdm_exp(logic [127:0] d, logic [7:0] ie, logic [7:0] oe);
    logic [127:0] e;
    e = d;
    for (int g = 0; g < 4; g++)
      if (!(ie[7-g] && oe[7-g])) e[127-32*g -: 32] = '0;
    return e;
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    logic [7:0] rx;
    logic [2:0] ack;
    host.start();
    host.xfer(8'h9C, rx, ack[2]);
    host.xfer(ofs, rx, ack[1]);
    host.xfer(val, rx, ack[0]);
    host.stop();
    `CHECK("write ack", 3'b000, ack)
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] rx;
    logic [2:0] ack;
    logic       nack;
    host.start();
    host.xfer(8'h9C, rx, ack[2]);
    host.xfer(ofs, rx, ack[1]);
    host.start();
    host.xfer(8'h9D, rx, ack[0]);
    host.xfer(8'hFF, rx, nack);
    host.stop();
    `CHECK("read ack", 3'b000, ack)
    `CHECK("read data", exp, rx)
  endtask

  task automatic wait_sleep(input int lim, output int n);
    n = 0;
    while (sleeping !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      $display("ERROR sleeping expected 1 seen %0h", sleeping);
      bad_count++;
      print_verdict();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    $display("ERROR run expected finish seen timeout");
    bad_count++;
    print_verdict();
  end

  initial begin
    logic [7:0]   ie;
    logic [7:0]   oe;
    logic [7:0]   ofs [8];
    logic [7:0]   val [8];
    logic [127:0] cap;
    logic [7:0]   rx;
    logic         ack;
    int           n;
    bad_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    chan_data = '0;
    seed = $urandom(24);
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    host.start();
    host.xfer(8'h9C, rx, ack);
    host.stop();
    `CHECK("init ack", 1'b1, ack)
    wait_sleep(INIT, n);
    host.start();
    host.xfer(8'h9E, rx, ack);
    host.stop();
    `CHECK("foreign ack", 1'b1, ack)
    $display("test init and address finished");
    ie = 8'hF0;
    oe = 8'hF0;
    for (int p = 0; p < 2; p++) begin
      wr(8'h02, 8'h81);
      repeat (4) @(negedge clk);
      `CHECK("regulator", 1'b1, regulator_internal)
      `CHECK("awake", 1'b0, sleeping)
      repeat (WAKE) @(negedge clk);
      if (p == 1) rd(8'h73, ie);
      if (p == 1) ie = 8'($urandom) & 8'hF0;
      if (p == 1) oe = 8'($urandom) & 8'hF0;
      ofs = '{8'h41, 8'h3B, 8'h22, 8'h2B, 8'h73, 8'h74, 8'h75, 8'h50};
      val = '{8'h40, 8'h70, 8'h41, 8'h45, ie, oe, 8'h60, 8'h5A};
      for (int k = 0; k < 8; k++) wr(ofs[k], val[k]);
      repeat (4) @(negedge clk);
      `CHECK("powered", 2'b11, {converter_on, pll_on})
      for (int k = 0; k < 8; k++) rd(ofs[k], k == 7 ? 8'h00 : val[k]);
      rd(8'h77, 8'h00);
      chan_data = {$urandom, $urandom, $urandom, $urandom};
      host.frame(cap);
      `CHECK("tdm frame", tdm_exp(chan_data, ie, oe), cap)
      wr(8'h02, 8'h80);
      wait_sleep(SLP + 50, n);
      `CHECK("ramp time", 1'b1, n <= SLP && n > SLP / 2)
      `CHECK("powered down", 2'b00, {converter_on, pll_on})
      rd(8'h77, 8'h80);
      $display("test wake record sleep pass %0d finished", p);
    end
    wr(8'h01, 8'h01);
    repeat (4) @(negedge clk);
    `CHECK("reset sleep", 1'b1, sleeping)
    rd(8'h73, 8'h00);
    $display("test software reset finished");
    wr(8'h02, 8'h80);
    repeat (4) @(negedge clk);
    `CHECK("regulator set", 1'b1, regulator_internal)
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    `CHECK("reset asleep", 1'b0, sleeping)
    `CHECK("reset regulator", 1'b0, regulator_internal)
    wait_sleep(INIT + 10, n);
    $display("test power cycle finished");
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
